// [hw/pin_unit_pkg.sv]
// Shared constants and types for the pin instruction unit
package pin_unit_pkg;
  // Register byte addresses
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_D    = 8'h04;
  localparam logic [7:0] A_S    = 8'h08;
  localparam logic [7:0] A_Q    = 8'h0c;
  localparam logic [7:0] A_FLG  = 8'h10;
  localparam logic [7:0] A_RES  = 8'h14;
  localparam logic [7:0] A_DIRL = 8'h18;
  localparam logic [7:0] A_DIRH = 8'h1c;
  localparam logic [7:0] A_OUTL = 8'h20;
  localparam logic [7:0] A_OUTH = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  // Command word fields
  localparam int F_SRC = 0;
  localparam int F_GRP = 3;
  localparam int F_WC  = 6;
  localparam int F_WZ  = 7;
  localparam int F_CMB = 8;
  // Operand fields
  localparam int F_BASE     = 0;
  localparam int F_CNT      = 6;
  localparam int F_SCP_EN   = 6;
  localparam int F_SCP_BASE = 2;
  // Operation groups
  localparam logic [2:0] G_DIR  = 3'h0;
  localparam logic [2:0] G_DRV  = 3'h1;
  localparam logic [2:0] G_FLT  = 3'h2;
  localparam logic [2:0] G_OUT  = 3'h3;
  localparam logic [2:0] G_TST  = 3'h4;
  localparam logic [2:0] G_TSTN = 3'h5;
  localparam logic [2:0] G_SP   = 3'h6;
  localparam logic [2:0] G_SP2  = 3'h7;
  // Bit sources of the pin groups
  localparam logic [2:0] S_C    = 3'h0;
  localparam logic [2:0] S_ONE  = 3'h1;
  localparam logic [2:0] S_ZERO = 3'h2;
  localparam logic [2:0] S_NC   = 3'h3;
  localparam logic [2:0] S_NOT  = 3'h4;
  localparam logic [2:0] S_NZ   = 3'h5;
  localparam logic [2:0] S_RND  = 3'h6;
  localparam logic [2:0] S_Z    = 3'h7;
  // Smart-pin sub-operations
  localparam logic [2:0] SP_ACK   = 3'h0;
  localparam logic [2:0] SP_SCPRD = 3'h1;
  localparam logic [2:0] SP_RDACK = 3'h2;
  localparam logic [2:0] SP_RDQ   = 3'h3;
  localparam logic [2:0] SP_DAC   = 3'h4;
  localparam logic [2:0] SP_SCPCF = 3'h5;
  localparam logic [2:0] SP_MODE  = 3'h6;
  localparam logic [2:0] SP_X     = 3'h7;
  localparam logic [2:0] SP2_Y    = 3'h0;
  // Flag combine modes of the pin tests
  localparam logic [1:0] CMB_WR  = 2'h0;
  localparam logic [1:0] CMB_OR  = 2'h1;
  localparam logic [1:0] CMB_AND = 2'h2;
  localparam logic [1:0] CMB_XOR = 2'h3;
  // Reset values
  localparam logic [63:0] RST_SEED = 64'h9e37_79b9_7f4a_7c15;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic {ST_IDLE, ST_EXEC} st_e;

  typedef struct packed {
    logic [63:0] mask;
    logic        ack;
    logic        wr_mode;
    logic        wr_x;
    logic        wr_y;
    logic [31:0] data;
  } sp_cmd_s;

  typedef struct packed {
    logic        rdy;
    logic        err;
    logic [31:0] rdata;
    logic [9:0]  cmd;
    logic [31:0] d;
    logic [31:0] s;
    logic [4:0]  q;
    logic        qv;
    logic        c;
    logic        z;
    st_e         st;
    logic [5:0]  base;
    logic [4:0]  cnt;
    logic [31:0] res;
    logic [63:0] dir;
    logic [63:0] out;
    logic [31:0] dac;
    logic        scp_en;
    logic [3:0]  scp_base;
    sp_cmd_s     sp;
    logic [5:0]  rd_pin;
    logic [63:0] sync1;
    logic [63:0] sync2;
  } unit_s;
endpackage : pin_unit_pkg

// [hw/pin_range_mask.sv]
// Pin range mask with wrap inside the low or high group
`timescale 1ns/1ps
module pin_range_mask (
  input  wire logic [5:0]  i_base,
  input  wire logic [4:0]  i_cnt,
  output logic      [63:0] o_mask
);
  logic [31:0] grp;
  logic [4:0]  off;

  always_comb begin
    grp = '0;
    off = '0;
    for (int i = 0; i < 32; i++) begin
      off = 5'(i) - i_base[4:0];
      grp[i] = (off <= i_cnt);
    end
    o_mask = i_base[5] ? {grp, 32'h0000_0000} : {32'h0000_0000, grp};
  end
endmodule : pin_range_mask

// [hw/pin_prng.sv]
// Free-running 64-bit xorshift source, one bit per pin
`timescale 1ns/1ps
module pin_prng (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_clk_en,
  output logic      [63:0] o_bits
);
  logic [63:0] st_q;
  logic [63:0] st_d;

  always_comb begin
    st_d = st_q ^ (st_q << 13);
    st_d = st_d ^ (st_d >> 7);
    st_d = st_d ^ (st_d << 17);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_q <= pin_unit_pkg::RST_SEED;
    end else if (i_clk_en) begin
      st_q <= st_d;
    end
  end

  assign o_bits = st_q;
endmodule : pin_prng

// [hw/pin_instruction_unit.sv]
// Pin and smart-pin instruction execution unit with APB register access
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Direction ops act on pins base..base+count; flags take resulting bit
// [RQ2] Direction ranges wrap inside their own 32-pin group
// [RQ3] A pending prefix count replaces the operand count once
// [RQ4] Direction sources: C, 1, 0, !C, toggle, !Z, random, Z
// [RQ5] Drive ops set output bits and force direction bits high
// [RQ6] Float ops set output bits and force direction bits low
// [RQ7] Output ops leave direction alone; flags take resulting output bit
// [RQ8] Random source gives each pin its own bit
// [RQ9] Pin test writes or combines the input bit into C or Z
// [RQ10] Inverted pin test uses the complemented input bit
// [RQ11] Acknowledge op acknowledges every smart pin in the S range
// [RQ12] Smart ranges wrap in group; prefix count replaces S count
// [RQ13] Scope read packs channel 3 high down to channel 0 low
// [RQ14] Acknowledging read returns result, acknowledges pin, modal bit to C
// [RQ15] Quiet read returns result and modal bit without acknowledge
// [RQ16] DAC set splits operand into four channel bytes
// [RQ17] Scope configure takes enable from bit 6, base from 5..2
// [RQ18] Mode write stores D into the S range and acknowledges
// [RQ19] X and Y writes store D into the S range and acknowledge
// [RQ20] Every operation completes two clocks after issue
module pin_instruction_unit (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_srst,
  input  wire logic                      i_clk_en,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [7:0]                i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic                           o_pready,
  output logic      [31:0]               o_prdata,
  output logic                           o_pslverr,
  input  wire logic [63:0]               i_pin_in,
  output logic      [63:0]               o_dir,
  output logic      [63:0]               o_out,
  output pin_unit_pkg::sp_cmd_s          o_sp,
  output logic      [5:0]                o_sp_rd_pin,
  input  wire logic [31:0]               i_sp_rdata,
  input  wire logic                      i_sp_modal,
  input  wire logic [3:0][7:0]           i_scope_ch,
  output logic      [3:0][7:0]           o_dac,
  output logic                           o_scope_en,
  output logic      [3:0]                o_scope_base
);
  pin_unit_pkg::unit_s q;
  pin_unit_pkg::unit_s n;
  logic [63:0] mask;
  logic [63:0] rnd;
  logic        acc;
  logic        wr;
  logic        ex;
  logic        issue;

  function automatic logic comb_flag(input logic f, input logic b, input logic [1:0] op);
    case (op)
      pin_unit_pkg::CMB_OR:  comb_flag = f | b;
      pin_unit_pkg::CMB_AND: comb_flag = f & b;
      pin_unit_pkg::CMB_XOR: comb_flag = f ^ b;
      default:               comb_flag = b;
    endcase
  endfunction : comb_flag

  function automatic logic hit(input logic [7:0] a);
    hit = (a[1:0] == 2'h0) && (a <= pin_unit_pkg::A_STAT);
  endfunction : hit

  // [RQ1] [RQ2] Range mask with group wrap
  pin_range_mask u_mask (
    .i_base (q.base),
    .i_cnt  (q.cnt),
    .o_mask (mask)
  );

  // [RQ8] Independent bit per pin
  pin_prng u_prng (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_clk_en  (i_clk_en),
    .o_bits    (rnd)
  );

  assign acc   = i_psel & i_penable;
  assign wr    = acc & q.rdy & i_pwrite;
  assign issue = wr & (i_paddr == pin_unit_pkg::A_CMD) & i_clk_en;
  assign ex    = (q.st == pin_unit_pkg::ST_EXEC) & i_clk_en;

  always_comb begin
    logic [2:0]  grp;
    logic [2:0]  src;
    logic [31:0] op;
    logic [63:0] cur;
    logic [63:0] v;
    logic [63:0] nb;
    logic        b;
    grp = q.cmd[pin_unit_pkg::F_GRP +: 3];
    src = q.cmd[pin_unit_pkg::F_SRC +: 3];
    op  = '0;
    cur = (grp == pin_unit_pkg::G_DIR) ? q.dir : q.out;
    v   = '0;
    nb  = '0;
    b   = 1'b0;
    n   = q;
    n.sync1 = i_pin_in;
    n.sync2 = q.sync1;
    n.sp    = '0;
    // Bus answer one cycle into the access phase, held off while busy
    n.rdy   = acc & ~q.rdy & (q.st == pin_unit_pkg::ST_IDLE);
    if (n.rdy) begin
      n.err = ~hit(i_paddr);
      case (i_paddr)
        pin_unit_pkg::A_CMD:  n.rdata = {22'h0, q.cmd};
        pin_unit_pkg::A_D:    n.rdata = q.d;
        pin_unit_pkg::A_S:    n.rdata = q.s;
        pin_unit_pkg::A_Q:    n.rdata = {27'h0, q.q};
        pin_unit_pkg::A_FLG:  n.rdata = {30'h0, q.z, q.c};
        pin_unit_pkg::A_RES:  n.rdata = q.res;
        pin_unit_pkg::A_DIRL: n.rdata = q.dir[31:0];
        pin_unit_pkg::A_DIRH: n.rdata = q.dir[63:32];
        pin_unit_pkg::A_OUTL: n.rdata = q.out[31:0];
        pin_unit_pkg::A_OUTH: n.rdata = q.out[63:32];
        pin_unit_pkg::A_STAT: n.rdata = {30'h0, q.qv, 1'b0};
        default:              n.rdata = pin_unit_pkg::RST_WORD;
      endcase
    end
    if (wr) begin
      case (i_paddr)
        pin_unit_pkg::A_CMD: begin
          n.cmd = i_pwdata[9:0];
          n.st  = pin_unit_pkg::ST_EXEC;
          op    = (i_pwdata[5] & i_pwdata[4]) ? q.s : q.d;
          n.base = op[pin_unit_pkg::F_BASE +: 6];
          // [RQ3] [RQ12] Prefix count overrides operand count
          n.cnt  = q.qv ? q.q : op[pin_unit_pkg::F_CNT +: 5];
          n.qv   = 1'b0;
          n.rd_pin = q.s[5:0];
        end
        pin_unit_pkg::A_D: n.d = i_pwdata;
        pin_unit_pkg::A_S: n.s = i_pwdata;
        pin_unit_pkg::A_Q: begin
          n.q  = i_pwdata[4:0];
          n.qv = 1'b1;
        end
        pin_unit_pkg::A_FLG: begin
          n.c = i_pwdata[0];
          n.z = i_pwdata[1];
        end
        default: ;
      endcase
    end
    if (q.st == pin_unit_pkg::ST_EXEC) begin
      // [RQ20] Commit on the second clock
      n.st = pin_unit_pkg::ST_IDLE;
      // [RQ4] [RQ8] Bit source per pin
      case (src)
        pin_unit_pkg::S_C:    v = {64{q.c}};
        pin_unit_pkg::S_ONE:  v = '1;
        pin_unit_pkg::S_ZERO: v = '0;
        pin_unit_pkg::S_NC:   v = {64{~q.c}};
        pin_unit_pkg::S_NOT:  v = ~cur;
        pin_unit_pkg::S_NZ:   v = {64{~q.z}};
        pin_unit_pkg::S_RND:  v = rnd;
        default:              v = {64{q.z}};
      endcase
      nb = (cur & ~mask) | (v & mask);
      b  = nb[q.base];
      case (grp)
        pin_unit_pkg::G_DIR: begin
          // [RQ1] Load direction range
          n.dir = nb;
        end
        pin_unit_pkg::G_DRV, pin_unit_pkg::G_FLT, pin_unit_pkg::G_OUT: begin
          // [RQ7] Output range update
          n.out = nb;
          // [RQ5] Drive forces direction high
          if (grp == pin_unit_pkg::G_DRV) begin
            n.dir = q.dir | mask;
          end
          // [RQ6] Float forces direction low
          if (grp == pin_unit_pkg::G_FLT) begin
            n.dir = q.dir & ~mask;
          end
        end
        pin_unit_pkg::G_TST, pin_unit_pkg::G_TSTN: begin
          // [RQ9] [RQ10] Test input bit, maybe inverted
          b = q.sync2[q.base] ^ (grp == pin_unit_pkg::G_TSTN);
        end
        pin_unit_pkg::G_SP: begin
          case (src)
            pin_unit_pkg::SP_ACK: begin
              // [RQ11] Acknowledge range
              n.sp.mask = mask;
              n.sp.ack  = 1'b1;
            end
            pin_unit_pkg::SP_SCPRD: begin
              // [RQ13] Pack scope channels
              n.res = {i_scope_ch[3], i_scope_ch[2], i_scope_ch[1], i_scope_ch[0]};
            end
            pin_unit_pkg::SP_RDACK, pin_unit_pkg::SP_RDQ: begin
              // [RQ14] [RQ15] Result read, ack only when not quiet
              n.res     = i_sp_rdata;
              n.sp.mask = 64'h1 << q.rd_pin;
              n.sp.ack  = (src == pin_unit_pkg::SP_RDACK);
              if (q.cmd[pin_unit_pkg::F_WC]) begin
                n.c = i_sp_modal;
              end
            end
            pin_unit_pkg::SP_DAC: begin
              // [RQ16] Four DAC bytes
              n.dac = {q.d[31:24], q.d[23:16], q.d[15:8], q.d[7:0]};
            end
            pin_unit_pkg::SP_SCPCF: begin
              // [RQ17] Scope enable and base
              n.scp_en   = q.d[pin_unit_pkg::F_SCP_EN];
              n.scp_base = q.d[pin_unit_pkg::F_SCP_BASE +: 4];
            end
            default: begin
              // [RQ18] [RQ19] Mode or X write with acknowledge
              n.sp.mask    = mask;
              n.sp.ack     = 1'b1;
              n.sp.data    = q.d;
              n.sp.wr_mode = (src == pin_unit_pkg::SP_MODE);
              n.sp.wr_x    = (src == pin_unit_pkg::SP_X);
            end
          endcase
        end
        default: begin
          // [RQ19] Y write with acknowledge
          if (src == pin_unit_pkg::SP2_Y) begin
            n.sp.mask = mask;
            n.sp.ack  = 1'b1;
            n.sp.data = q.d;
            n.sp.wr_y = 1'b1;
          end
        end
      endcase
      if (~grp[2] | (grp == pin_unit_pkg::G_TST) | (grp == pin_unit_pkg::G_TSTN)) begin
        if (q.cmd[pin_unit_pkg::F_WC]) begin
          n.c = comb_flag(q.c, b, grp[2] ? q.cmd[pin_unit_pkg::F_CMB +: 2] : 2'h0);
        end
        if (q.cmd[pin_unit_pkg::F_WZ]) begin
          n.z = comb_flag(q.z, b, grp[2] ? q.cmd[pin_unit_pkg::F_CMB +: 2] : 2'h0);
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q    <= '0;
      q.st <= pin_unit_pkg::ST_IDLE;
    end else if (i_clk_en) begin
      q <= n;
    end
  end

  assign o_pready     = q.rdy;
  assign o_prdata     = q.rdata;
  assign o_pslverr    = q.err;
  assign o_dir        = q.dir;
  assign o_out        = q.out;
  assign o_sp         = q.sp;
  assign o_sp_rd_pin  = q.rd_pin;
  assign o_dac        = q.dac;
  assign o_scope_en   = q.scp_en;
  assign o_scope_base = q.scp_base;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_two_clock_done: assert property ( // [RQ20]
    issue ##1 i_clk_en |-> q.st == pin_unit_pkg::ST_EXEC ##1 q.st == pin_unit_pkg::ST_IDLE)
    else $error("operation not done in two clocks");
  a_prefix_count: assert property ( // [RQ3]
    issue && q.qv |=> q.cnt == $past(q.q) && !q.qv)
    else $error("prefix count not applied");
  a_group_wrap: assert property ( // [RQ2]
    q.base[5] ? mask[31:0] == 32'h0 : mask[63:32] == 32'h0)
    else $error("range spilled into other group");
  a_drive_dir: assert property ( // [RQ5]
    ex && q.cmd[5:3] == pin_unit_pkg::G_DRV |=> (o_dir & $past(mask)) == $past(mask))
    else $error("drive did not set direction");
  a_float_dir: assert property ( // [RQ6]
    ex && q.cmd[5:3] == pin_unit_pkg::G_FLT |=> (o_dir & $past(mask)) == 64'h0)
    else $error("float did not clear direction");
  a_out_keep_dir: assert property ( // [RQ7]
    ex && q.cmd[5:3] == pin_unit_pkg::G_OUT |=> o_dir == $past(o_dir))
    else $error("output op changed direction");
  a_quiet_noack: assert property ( // [RQ15]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_RDQ} |=> !o_sp.ack)
    else $error("quiet read acknowledged");
  a_dac_bytes: assert property ( // [RQ16]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_DAC}
    |=> o_dac[3] == $past(q.d[31:24]) && o_dac[0] == $past(q.d[7:0]))
    else $error("dac bytes misplaced");
  a_test_write: assert property ( // [RQ9]
    ex && q.cmd[5:3] == pin_unit_pkg::G_TST && q.cmd[6] && q.cmd[9:8] == 2'h0
    |=> q.c == $past(q.sync2[q.base]))
    else $error("pin test flag wrong");
  a_test_inv: assert property ( // [RQ10]
    ex && q.cmd[5:3] == pin_unit_pkg::G_TSTN && q.cmd[7] && q.cmd[9:8] == 2'h0
    |=> q.z == !$past(q.sync2[q.base]))
    else $error("inverted pin test flag wrong");
  a_dir_flag: assert property ( // [RQ1]
    ex && q.cmd[5:3] == pin_unit_pkg::G_DIR && q.cmd[6]
    |=> q.c == o_dir[$past(q.base)])
    else $error("direction flag not resulting bit");
  a_dir_toggle: assert property ( // [RQ4]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_DIR, pin_unit_pkg::S_NOT}
    |=> (o_dir & $past(mask)) == (~$past(q.dir) & $past(mask)))
    else $error("direction toggle wrong");
  a_ack_range: assert property ( // [RQ11]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_ACK}
    |=> o_sp.ack && o_sp.mask == $past(mask))
    else $error("acknowledge range wrong");
  a_scope_pack: assert property ( // [RQ13]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_SCPRD}
    |=> q.res[31:24] == $past(i_scope_ch[3]) && q.res[7:0] == $past(i_scope_ch[0]))
    else $error("scope samples misplaced");
  a_read_ack: assert property ( // [RQ14]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_RDACK}
    |=> o_sp.ack && o_sp.mask == (64'h1 << $past(q.rd_pin)) && q.res == $past(i_sp_rdata))
    else $error("acknowledging read wrong");
  a_scope_cfg: assert property ( // [RQ17]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_SCPCF}
    |=> o_scope_en == $past(q.d[pin_unit_pkg::F_SCP_EN])
        && o_scope_base == $past(q.d[pin_unit_pkg::F_SCP_BASE +: 4]))
    else $error("scope config wrong");
  a_mode_write: assert property ( // [RQ18]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_MODE}
    |=> o_sp.wr_mode && o_sp.ack && o_sp.data == $past(q.d))
    else $error("mode write wrong");
  a_y_write: assert property ( // [RQ19]
    ex && q.cmd[5:0] == {pin_unit_pkg::G_SP2, pin_unit_pkg::SP2_Y}
    |=> o_sp.wr_y && o_sp.ack && o_sp.mask == $past(mask))
    else $error("y write wrong");

  c_dir_op: cover property (ex && q.cmd[5:3] == pin_unit_pkg::G_DIR);
  c_rand_drive: cover property (ex && q.cmd[5:0] == {pin_unit_pkg::G_DRV, pin_unit_pkg::S_RND});
  c_wrap_range: cover property (ex && q.base[4:0] == 5'h1f && q.cnt != 5'h0);
  c_mode_write: cover property (ex && q.cmd[5:0] == {pin_unit_pkg::G_SP, pin_unit_pkg::SP_MODE});
  c_test_inv: cover property (ex && q.cmd[5:3] == pin_unit_pkg::G_TSTN);
endmodule : pin_instruction_unit

// [dv/sp_cells_model.sv]
// Behavioural smart pin cells: result words, modal bit and scope samples
`timescale 1ns/1ps
module sp_cells_model (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_srst,
  input  wire pin_unit_pkg::sp_cmd_s i_sp,
  input  wire logic [5:0]            i_rd_pin,
  output logic      [31:0]           o_rdata,
  output logic                       o_modal,
  output logic      [3:0][7:0]       o_scope_ch
);
  logic [31:0] res_q [64];
  logic [31:0] mode_q;
  // Result loops back the X word; scope shows the mode word
  always_ff @(posedge i_clk_sys) begin
    for (int i = 0; i < 64; i++) begin
      if (i_srst) begin
        res_q[i] <= 32'(i);
      end else if (i_sp.mask[i] && i_sp.wr_x) begin
        res_q[i] <= i_sp.data;
      end
    end
    if (i_srst) begin
      mode_q <= 32'h0;
    end else if (i_sp.wr_mode) begin
      mode_q <= i_sp.data;
    end
  end
  assign o_rdata    = res_q[i_rd_pin];
  assign o_modal    = res_q[i_rd_pin][31];
  assign o_scope_ch = mode_q;
endmodule : sp_cells_model

// [dv/tb.sv]
// Self-checking bench for the pin instruction unit
`timescale 1ns/1ps
module tb;
  logic clk, srst, psel, pen, pwr, prdy, perr, modal, scp_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, sp_rdata, e_mode, q_val, r, d;
  logic [63:0] pin_in, dir, out, e_dir, e_out;
  logic [3:0][7:0] scope, dac;
  logic [3:0] scp_base;
  logic [5:0] rd_pin;
  logic e_c, e_z, q_pend;
  logic [31:0] xw [64];
  pin_unit_pkg::sp_cmd_s sp, sp_last;
  int err_count, num_checks, sp_cnt, seed;

  pin_instruction_unit i_pin_instruction_unit (.i_clk_sys(clk), .i_srst(srst), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(prdy), .o_prdata(prdata), .o_pslverr(perr), .i_pin_in(pin_in), .o_dir(dir),
    .o_out(out), .o_sp(sp), .o_sp_rd_pin(rd_pin), .i_sp_rdata(sp_rdata), .i_sp_modal(modal),
    .i_scope_ch(scope), .o_dac(dac), .o_scope_en(scp_en), .o_scope_base(scp_base));
  sp_cells_model i_sp_cells_model (.i_clk_sys(clk), .i_srst(srst), .i_sp(sp),
    .i_rd_pin(rd_pin), .o_rdata(sp_rdata), .o_modal(modal), .o_scope_ch(scope));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (sp.ack === 1'b1) begin
    sp_last = sp;
    sp_cnt++;
  end

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
      tally_and_finish();
    end
    rd = prdata;
    er = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, v, x, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask : rd
  task automatic setf(input logic [1:0] f);
    wr(pin_unit_pkg::A_FLG, {30'h0, f});
    {e_z, e_c} = f;
  endtask : setf
  function automatic logic [63:0] rmask(input logic [5:0] b, input logic [4:0] n);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i <= int'(n); i++) m[{b[5], 5'(b[4:0] + i)}] = 1'b1;
    return m;
  endfunction : rmask
  function automatic logic fold(input logic f, input logic b, input logic [1:0] cb);
    return cb == 2'h0 ? b : cb == 2'h1 ? f | b : cb == 2'h2 ? f & b : f ^ b;
  endfunction : fold

  task automatic pin_op(input logic [2:0] g, input logic [2:0] s, input logic [31:0] dv,
                        input logic wc, input logic wz);
    logic [63:0] m, t, v;
    logic [31:0] x;
    logic b;
    m = rmask(dv[5:0], q_pend ? q_val[4:0] : dv[10:6]);
    q_pend = 1'b0;
    t = (g == pin_unit_pkg::G_DIR) ? e_dir : e_out;
    v = ~t;
    if (s == pin_unit_pkg::S_C || s == pin_unit_pkg::S_NC) v = {64{e_c ^ s[0]}};
    if (s == pin_unit_pkg::S_Z || s == pin_unit_pkg::S_NZ) v = {64{e_z ^ !s[1]}};
    if (s == pin_unit_pkg::S_ONE || s == pin_unit_pkg::S_ZERO) v = {64{s[0]}};
    wr(pin_unit_pkg::A_D, dv);
    wr(pin_unit_pkg::A_CMD, {2'h0, wz, wc, g, s});
    rd(pin_unit_pkg::A_STAT, x);
    chk(x, 0);
    if (s == pin_unit_pkg::S_RND) begin
      v = (g == pin_unit_pkg::G_DIR) ? dir : out;
      chk((v & m) == m || (v & m) == 0, 0);
    end
    t = (t & ~m) | (v & m);
    b = t[dv[5:0]];
    if (g == pin_unit_pkg::G_DIR) e_dir = t;
    else e_out = t;
    if (g == pin_unit_pkg::G_DRV) e_dir |= m;
    if (g == pin_unit_pkg::G_FLT) e_dir &= ~m;
    if (wc) e_c = b;
    if (wz) e_z = b;
    chk(dir, e_dir);
    chk(out, e_out);
    rd(pin_unit_pkg::A_FLG, x);
    chk(x[1:0], {e_z, e_c});
  endtask : pin_op

  task automatic sp_op(input logic [3:0] k, input logic [31:0] dv, input logic [31:0] sv);
    logic [63:0] m;
    logic [31:0] x;
    logic [2:0] g;
    int c0;
    g = k[3] ? pin_unit_pkg::G_SP2 : pin_unit_pkg::G_SP;
    m = rmask(sv[5:0], q_pend ? q_val[4:0] : sv[10:6]);
    q_pend = 1'b0;
    wr(pin_unit_pkg::A_D, dv);
    wr(pin_unit_pkg::A_S, sv);
    c0 = sp_cnt;
    wr(pin_unit_pkg::A_CMD, {4'h1, g, k[2:0]});
    rd(pin_unit_pkg::A_RES, x);
    case ({g, k[2:0]})
      {pin_unit_pkg::G_SP, pin_unit_pkg::SP_ACK}: chk(sp_last.mask, m);
      {pin_unit_pkg::G_SP, pin_unit_pkg::SP_SCPRD}: chk(x, e_mode);
      {pin_unit_pkg::G_SP, pin_unit_pkg::SP_RDACK}: begin
        chk(x, xw[sv[5:0]]);
        chk(sp_last.mask, 64'h1 << sv[5:0]);
        e_c = xw[sv[5:0]][31];
      end
      {pin_unit_pkg::G_SP, pin_unit_pkg::SP_RDQ}: begin
        chk(x, xw[sv[5:0]]);
        e_c = xw[sv[5:0]][31];
      end
      {pin_unit_pkg::G_SP, pin_unit_pkg::SP_DAC}: chk(dac, dv);
      {pin_unit_pkg::G_SP, pin_unit_pkg::SP_SCPCF}: chk({scp_en, scp_base}, dv[6:2]);
      default: begin
        chk(sp_last.mask, m);
        chk(sp_last.data, dv);
        chk({sp_last.wr_mode, sp_last.wr_x, sp_last.wr_y}, {k == 6, k == 7, k == 8});
        if (k == 6) e_mode = dv;
        for (int i = 0; i < 64; i++) if (k == 7 && m[i]) xw[i] = dv;
      end
    endcase
    chk(sp_cnt - c0, (k == 1 || k == 3 || k == 4 || k == 5) ? 0 : 1);
    rd(pin_unit_pkg::A_FLG, x);
    chk(x[1:0], {e_z, e_c});
  endtask : sp_op

  task automatic prefix(input logic [4:0] n);
    logic [31:0] x;
    q_val = {27'h0, n};
    wr(pin_unit_pkg::A_Q, q_val);
    q_pend = 1'b1;
    rd(pin_unit_pkg::A_STAT, x);
    chk(x, 2);
  endtask : prefix

  initial begin
    #(50 * 60000);
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic e;
    seed = 96;
    {psel, pen, pwr, paddr, pwdata, pin_in, srst} = '0;
    {e_dir, e_out, e_c, e_z, q_pend, e_mode, err_count, num_checks, sp_cnt} = '0;
    for (int i = 0; i < 64; i++) xw[i] = 32'(i);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk(dir, 64'h0);
    chk(out, 64'h0);
    rd(pin_unit_pkg::A_FLG, r);
    chk(r, 0);
    apb(1'b0, 8'h2c, 32'h0, r, e);
    chk({e, r}, 33'h1_0000_0000);
    apb(1'b1, 8'h05, 32'h0, r, e);
    chk(e, 1);
    for (int k = 0; k < 96; k++) begin
      d = $random(seed);
      r = $random(seed);
      if (k < 8) d[10:0] = {5'h1f, k[0], 5'h1f};
      if (k[4:2] == pin_unit_pkg::S_RND) d[10:6] = 5'h1f;
      setf(r[1:0]);
      if (r[5:4] == 2'h0 && k[4:2] != pin_unit_pkg::S_RND) prefix(r[12:8]);
      pin_op({1'b0, k[1:0]}, k[4:2], d, r[2], r[3]);
    end
    pin_in <= {$random(seed), $random(seed)};
    repeat (4) @(posedge clk);
    for (int k = 0; k < 32; k++) begin
      r = $random(seed);
      setf(r[1:0]);
      d = $random(seed);
      d[1:0] = (k[3:2] == 2'h0) ? 2'h3 : k[3:2];
      e_c = d[0] ? fold(e_c, pin_in[r[13:8]] ^ k[4], k[1:0]) : e_c;
      e_z = d[1] ? fold(e_z, pin_in[r[13:8]] ^ k[4], k[1:0]) : e_z;
      wr(pin_unit_pkg::A_D, {26'h0, r[13:8]});
      wr(pin_unit_pkg::A_CMD, {k[1:0], d[1:0], 2'h2, k[4], 3'h0});
      rd(pin_unit_pkg::A_FLG, r);
      chk(r[1:0], {e_z, e_c});
    end
    for (int k = 0; k < 45; k++) begin
      r = $random(seed);
      if (k % 5 == 0) prefix(r[4:0]);
      sp_op(4'(k % 9), $random(seed), r);
    end
    tally_and_finish();
  end
endmodule : tb
